//--- src/gst_map.vh
`ifndef GST_MAP_VH
`define GST_MAP_VH
// register indices
`define GST_A_CTRL     3'h0
`define GST_A_CNT_LO   3'h1
`define GST_A_CNT_HI   3'h2
`define GST_A_IRQ      3'h3
`define GST_A_CCP_LO   3'h4
`define GST_A_CCP_HI   3'h5
`define GST_A_CCP_MODE 3'h6
// control fields
`define GST_B_ON      0
`define GST_B_CS      1
`define GST_B_BYPASS  2
`define GST_B_LPOSC   3
`define GST_B_PS_LO   4
`define GST_B_PS_HI   5
`define GST_B_GE      6
`define GST_B_GPOL    7
// irq register fields
`define GST_B_FLAG    0
`define GST_B_RIE     1
`define GST_B_PIE     2
`define GST_B_GIE     3
`define GST_B_GSS     4
// capture/compare mode fields
`define GST_B_CAP     0
`define GST_B_CMP     1
`define GST_B_SPEC    2
// reset values
`define GST_R_CTRL    8'h00
`define GST_R_IRQ     5'h00
`define GST_R_MODE    3'h0
`define GST_R_CNT     16'h0000
`define GST_R_CCP     16'h0000
// counter limits
`define GST_CNT_MAX   16'hffff
// system clocks per instruction cycle
`define GST_INST_DIV  4
`endif

//--- src/gst_timer.v
// Added by the designer: the address map and the plain strobed port.
`include "gst_map.vh"
`timescale 1ns/10ps
`default_nettype none
module gst_timer #(
   parameter INST_DIV = `GST_INST_DIV
) (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire [2:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       ext_count_clock_pin,
   input  wire       gate_pin,
   input  wire       second_comparator_output,
   input  wire       cpu_sleeping,
   input  wire       capture_event,
   output wire       lowpower_osc_on,
   output wire       cmp_sync_tick,
   output reg        compare_event,
   output wire       cpu_irq,
   output wire       cpu_wake,
   output wire       wake_to_vector
);
////////////////////////////////////////////////////////////////////////
// registers
reg  [7:0]  ctrl_q;
reg  [4:0]  irqr_q;
reg  [2:0]  mode_q;
reg  [15:0] count_q;
reg  [15:0] count_d;
reg  [15:0] ccp_q;
reg  [2:0]  pre_q;
reg  [1:0]  inst_q;
reg         ext_lvl_q;
reg         pend_q;
reg         cmp_prev_q;
reg         flag_d;
reg         ext_tick;
reg         src_tick;
reg         gate_raw;
reg         gate_act;
reg  [2:0]  arm_q;
reg  [2:0]  arm_d;
wire [2:0]  pin_in;
wire [2:0]  pin_ok;
////////////////////////////////////////////////////////////////////////
// control fields
wire       counter_on            = ctrl_q[`GST_B_ON];
wire       clock_source_select   = ctrl_q[`GST_B_CS];
wire       ext_clock_sync_bypass = ctrl_q[`GST_B_BYPASS];
wire [1:0] input_prescale_select = ctrl_q[`GST_B_PS_HI:`GST_B_PS_LO];
wire       gate_enable_bit       = ctrl_q[`GST_B_GE];
wire       gate_polarity         = ctrl_q[`GST_B_GPOL];
wire       rollover_flag         = irqr_q[`GST_B_FLAG];
wire       rollover_irq_enable   = irqr_q[`GST_B_RIE];
wire       peripheral_irq_enable = irqr_q[`GST_B_PIE];
wire       global_irq_enable     = irqr_q[`GST_B_GIE];
wire       gate_source_select    = irqr_q[`GST_B_GSS];
wire       wr_ctrl = reg_wr && (reg_addr == `GST_A_CTRL);
wire       wr_lo   = reg_wr && (reg_addr == `GST_A_CNT_LO);
wire       wr_hi   = reg_wr && (reg_addr == `GST_A_CNT_HI);
wire       wr_cnt  = wr_lo || wr_hi;
wire       wr_irq  = reg_wr && (reg_addr == `GST_A_IRQ);
wire       wr_mode = reg_wr && (reg_addr == `GST_A_CCP_MODE);
wire       wr_c_lo = reg_wr && (reg_addr == `GST_A_CCP_LO);
wire       wr_c_hi = reg_wr && (reg_addr == `GST_A_CCP_HI);
////////////////////////////////////////////////////////////////////////
// pin synchronisers, three stages each
assign pin_in = {second_comparator_output, gate_pin, ext_count_clock_pin};
genvar gi;
generate
   for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      always @(posedge clk) begin
         if (sys_rst) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
         end else begin
            s1_q <= pin_in[gi];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
         end
      end
      assign pin_ok[gi] = lvl_q;
   end
endgenerate
////////////////////////////////////////////////////////////////////////
// instruction clock tick
wire inst_tick = (inst_q == INST_DIV[1:0] - 2'd1);
always @(posedge clk) begin
   if (sys_rst) begin
      inst_q <= 2'd0;
   end else if (inst_tick) begin
      inst_q <= 2'd0;
   end else begin
      inst_q <= inst_q + 2'd1;
   end
end
////////////////////////////////////////////////////////////////////////
// count pin arming, one-hot
localparam [2:0] ARM_IDLE = 3'b001;
localparam [2:0] ARM_WAIT = 3'b010;
localparam [2:0] ARM_LIVE = 3'b100;
always @* begin
   arm_d = arm_q;
   case (arm_q)
      ARM_IDLE: begin
         if (counter_on) begin
            arm_d = ARM_WAIT;
         end
      end
      ARM_WAIT: begin
         if (!pin_ok[0]) begin
            arm_d = ARM_LIVE;
         end
      end
      ARM_LIVE: begin
         arm_d = ARM_LIVE;
      end
      default: begin
         arm_d = ARM_IDLE;
      end
   endcase
   if (!counter_on) begin
      arm_d = ARM_IDLE;
   end else if (wr_cnt) begin
      arm_d = ARM_WAIT;
   end
end
////////////////////////////////////////////////////////////////////////
// external edge handling
wire ext_rise = pin_ok[0] && !ext_lvl_q;
wire ext_edge = ext_rise && (arm_q == ARM_LIVE);
always @(posedge clk) begin
   if (sys_rst) begin
      ext_lvl_q <= 1'b0;
      arm_q     <= ARM_IDLE;
      pend_q    <= 1'b0;
   end else begin
      ext_lvl_q <= pin_ok[0];
      arm_q     <= arm_d;
      if (ext_clock_sync_bypass || inst_tick) begin
         pend_q <= 1'b0;
      end else if (ext_edge) begin
         pend_q <= 1'b1;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// sync mode waits for the instruction phase, bypass counts at once
always @* begin
   if (ext_clock_sync_bypass) begin
      ext_tick = ext_edge;
   end else begin
      ext_tick = inst_tick && (pend_q || ext_edge);
   end
   if (clock_source_select) begin
      src_tick = ext_tick;
   end else begin
      src_tick = inst_tick;
   end
end
////////////////////////////////////////////////////////////////////////
// gate and run conditions
always @* begin
   if (gate_source_select) begin
      gate_raw = pin_ok[2];
   end else begin
      gate_raw = pin_ok[1];
   end
   if (gate_polarity) begin
      gate_act = gate_raw;
   end else begin
      gate_act = !gate_raw;
   end
end
wire gate_ok   = !gate_enable_bit || gate_act;
wire async_ext = clock_source_select && ext_clock_sync_bypass;
wire run_ok    = !cpu_sleeping || async_ext;
wire count_en  = counter_on && gate_ok && run_ok;
assign cmp_sync_tick = src_tick && counter_on;
////////////////////////////////////////////////////////////////////////
// prescaler
reg [2:0] pre_mask;
always @* begin
   case (input_prescale_select)
      2'b00:   pre_mask = 3'h0;
      2'b01:   pre_mask = 3'h1;
      2'b10:   pre_mask = 3'h3;
      default: pre_mask = 3'h7;
   endcase
end
wire step    = src_tick && count_en;
wire pre_hit = ((pre_q & pre_mask) == pre_mask);
wire inc     = step && pre_hit;
always @(posedge clk) begin
   if (sys_rst) begin
      pre_q <= 3'h0;
   end else if (wr_cnt) begin
      pre_q <= 3'h0;
   end else if (step) begin
      pre_q <= pre_hit ? 3'h0 : pre_q + 3'h1;
   end
end
////////////////////////////////////////////////////////////////////////
// capture / compare
wire cmp_match = mode_q[`GST_B_CMP] && (ccp_q == count_q);
wire spec_trig = cmp_match && mode_q[`GST_B_SPEC] &&
                 !async_ext;
wire rollover  = inc && (count_q == `GST_CNT_MAX);
always @(posedge clk) begin
   if (sys_rst) begin
      ccp_q         <= `GST_R_CCP;
      mode_q        <= `GST_R_MODE;
      compare_event <= 1'b0;
      cmp_prev_q    <= 1'b0;
   end else begin
      cmp_prev_q    <= cmp_match;
      compare_event <= cmp_match && !cmp_prev_q;
      if (wr_mode) begin
         mode_q <= reg_wdata[2:0];
      end
      if (mode_q[`GST_B_CAP] && capture_event) begin
         ccp_q <= count_q;
      end else if (wr_c_lo) begin
         ccp_q[7:0] <= reg_wdata;
      end else if (wr_c_hi) begin
         ccp_q[15:8] <= reg_wdata;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// counter
always @* begin
   count_d = count_q;
   if (wr_lo) begin
      count_d = {count_q[15:8], reg_wdata};
   end else if (wr_hi) begin
      count_d = {reg_wdata, count_q[7:0]};
   end else if (spec_trig && !cmp_prev_q) begin
      count_d = `GST_R_CNT;
   end else if (inc) begin
      count_d = count_q + 16'h0001;
   end
end
always @(posedge clk) begin
   if (sys_rst) begin
      count_q <= `GST_R_CNT;
   end else begin
      count_q <= count_d;
   end
end
////////////////////////////////////////////////////////////////////////
// control and interrupt registers
always @* begin
   flag_d = rollover_flag;
   if (wr_irq) begin
      flag_d = reg_wdata[`GST_B_FLAG];
   end
   if (rollover && !(spec_trig && !wr_cnt)) begin
      flag_d = 1'b1;
   end
end
always @(posedge clk) begin
   if (sys_rst) begin
      ctrl_q <= `GST_R_CTRL;
      irqr_q <= `GST_R_IRQ;
   end else begin
      if (wr_ctrl) begin
         ctrl_q <= reg_wdata;
      end
      if (wr_irq) begin
         irqr_q[4:1] <= reg_wdata[4:1];
      end
      irqr_q[`GST_B_FLAG] <= flag_d;
   end
end
assign lowpower_osc_on = ctrl_q[`GST_B_LPOSC];
wire wake_cond = rollover_flag && counter_on &&
                 rollover_irq_enable && peripheral_irq_enable;
assign cpu_wake       = wake_cond;
assign cpu_irq        = wake_cond && global_irq_enable;
assign wake_to_vector = global_irq_enable;
////////////////////////////////////////////////////////////////////////
// read port, data one cycle after the strobe
always @(posedge clk) begin
   if (sys_rst) begin
      reg_rdata <= 8'h00;
   end else if (reg_rd) begin
      case (reg_addr)
         `GST_A_CTRL:     reg_rdata <= ctrl_q;
         `GST_A_CNT_LO:   reg_rdata <= count_q[7:0];
         `GST_A_CNT_HI:   reg_rdata <= count_q[15:8];
         `GST_A_IRQ:      reg_rdata <= {3'h0, irqr_q};
         `GST_A_CCP_LO:   reg_rdata <= ccp_q[7:0];
         `GST_A_CCP_HI:   reg_rdata <= ccp_q[15:8];
         `GST_A_CCP_MODE: reg_rdata <= {5'h00, mode_q};
         default:         reg_rdata <= 8'h00;
      endcase
   end else begin
      reg_rdata <= 8'h00;
   end
end
endmodule // gst_timer
`default_nettype wire

//--- test/gst_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module gst_timer_props #(
   parameter INST_DIV = 4
) (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       lowpower_osc_on,
   input wire logic       compare_event,
   input wire logic       cpu_irq,
   input wire logic       cpu_wake,
   input wire logic       wake_to_vector
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
   a_irq_join: assert property (cpu_irq == (cpu_wake && wake_to_vector))
      else $error("irq not wake and vector");
   a_osc_follow: assert property (reg_wr && reg_addr == 3'h0
      |=> lowpower_osc_on == $past(reg_wdata[3])) else $error("osc enable wrong");
   a_osc_hold: assert property (!(reg_wr && reg_addr == 3'h0)
      |=> $stable(lowpower_osc_on)) else $error("osc enable moved");
   a_gie_follow: assert property (reg_wr && reg_addr == 3'h3
      |=> wake_to_vector == $past(reg_wdata[3])) else $error("vector select wrong");
   a_ctrl_readback: assert property (reg_rd && reg_addr == 3'h0
      |=> reg_rdata[3] == lowpower_osc_on) else $error("control readback wrong");
   a_cmp_pulse: assert property (compare_event |=> !compare_event)
      else $error("compare event too long");
   a_wake_sticky: assert property (cpu_wake && !(reg_wr && reg_addr[1:0] != 2'h1
      && reg_addr[1:0] != 2'h2) |=> cpu_wake) else $error("wake dropped alone");
endmodule // gst_timer_props
bind gst_timer gst_timer_props #(.INST_DIV(INST_DIV)) gst_timer_props_i (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .lowpower_osc_on(lowpower_osc_on), .compare_event(compare_event),
   .cpu_irq(cpu_irq), .cpu_wake(cpu_wake), .wake_to_vector(wake_to_vector));
`default_nettype wire

//--- test/gst_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module gst_pins_model (
   input  wire logic clk,
   input  wire logic run,
   input  wire logic gate_lvl,
   input  wire logic cmp_lvl,
   output var logic  ext_count_clock_pin,
   output wire logic gate_pin,
   output wire logic second_comparator_output,
   output var int    rises
);
   logic [2:0] ph_q;
   initial begin
      ext_count_clock_pin = 1'b0;
      ph_q = 3'h0;
      rises = 0;
   end
   ////////////////////////////////////////
   // levels of 5 clocks, idle low between bursts
   always @(posedge clk) begin
      if (run || ext_count_clock_pin) begin
         ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
         if (ph_q == 3'h4) begin
            ext_count_clock_pin <= !ext_count_clock_pin;
            rises <= rises + int'(!ext_count_clock_pin);
         end
      end
   end
   assign gate_pin = gate_lvl;
   assign second_comparator_output = cmp_lvl;
endmodule // gst_pins_model
`default_nettype wire

//--- test/gst_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module gst_timer_bench;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       cpu_sleeping = 1'b0;
   logic       capture_event = 1'b0;
   logic       run = 1'b0;
   logic       cmp_lvl = 1'b0;
   logic       gate_lvl = 1'b0;
   wire        sync_tick;
   wire  [7:0] reg_rdata;
   wire        ext_pin, gate_pin, cmp_out, lp_osc, cmp_evt, irq, wake, vec;
   int         rises, n, m, k, errors = 0, check_count = 0;
   logic [7:0] lo, hi;
   logic [7:0] tc_ctrl [10] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'hc1, 8'h41, 8'hc1, 8'h00,
                                8'hc1, 8'h09};
   logic [7:0] tc_exp [10] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h00, 8'h20, 8'h20, 8'h00,
                               8'h20, 8'h20};
   gst_timer #(.INST_DIV(4)) gst_timer_i (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_count_clock_pin(ext_pin), .gate_pin(gate_pin),
      .second_comparator_output(cmp_out), .cpu_sleeping(cpu_sleeping),
      .capture_event(capture_event), .lowpower_osc_on(lp_osc), .cmp_sync_tick(sync_tick),
      .compare_event(cmp_evt), .cpu_irq(irq), .cpu_wake(wake), .wake_to_vector(vec));
   gst_pins_model gst_pins_model_i (
      .clk(clk), .run(run), .gate_lvl(gate_lvl), .cmp_lvl(cmp_lvl),
      .ext_count_clock_pin(ext_pin), .gate_pin(gate_pin),
      .second_comparator_output(cmp_out), .rises(rises));
   ////////////////////////////////////////
   initial forever #5 clk = ~clk;
   task wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk) #1;
   endtask
   task rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk) #1;
      d = reg_rdata;
   endtask
   task idle(input int c);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (c) @(posedge clk);
      #1;
   endtask
   task restart(input logic [7:0] ctrl);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h0, ctrl);
   endtask
   task count16;
      wr(3'h0, 8'h00);
      rd(3'h1, lo);
      rd(3'h2, hi);
   endtask
   task give_verdict;
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #300000;
      errors++;
      give_verdict;
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      for (k = 0; k < 8; k++) begin
         if (k == 7) wr(3'h7, 8'hff);
         rd(k[2:0], lo);
         `CHK("reset", 8'h00, lo)
      end
      for (k = 0; k < 10; k++) begin
         cmp_lvl <= (k == 6);
         gate_lvl <= (k == 8);
         restart(8'h00);
         wr(3'h3, (k == 6) ? 8'h10 : 8'h00);
         idle(8);
         wr(3'h0, tc_ctrl[k]);
         idle(127);
         `CHK("osc", tc_ctrl[k][3], lp_osc)
         count16;
         `CHK("count", {8'h00, tc_exp[k]}, {hi, lo})
      end
      wr(3'h1, 8'hff);
      wr(3'h2, 8'hff);
      wr(3'h3, 8'h0e);
      wr(3'h0, 8'h01);
      idle(12);
      `CHK("irq", 1'b1, irq)
      wr(3'h3, 8'h0b);
      `CHK("masked", 1'b0, irq)
      `CHK("nowake", 1'b0, wake)
      wr(3'h3, 8'h07);
      `CHK("wake", 1'b1, wake)
      `CHK("vector", 1'b0, vec)
      wr(3'h3, 8'h06);
      `CHK("cleared", 1'b0, wake)
      for (k = 0; k < 2; k++) begin
         cpu_sleeping <= (k == 0);
         restart(k ? 8'h03 : 8'h07);
         idle(8);
         n = rises + 10;
         run <= 1'b1;
         for (int w = 0; w < 300 && rises != n; w++) @(posedge clk);
         run <= 1'b0;
         idle(30);
         cpu_sleeping <= 1'b0;
         count16;
         `CHK("ext", 16'h000a, {hi, lo})
      end
      wr(3'h4, 8'h05);
      wr(3'h5, 8'h00);
      wr(3'h6, 8'h06);
      restart(8'h01);
      idle(0);
      n = 0;
      m = 0;
      repeat (100) begin
         @(posedge clk) #1;
         n += int'(cmp_evt);
         m += int'(sync_tick);
      end
      count16;
      `CHK("sync", 25, m)
      `CHK("events", 1'b1, n > 0)
      `CHK("period", 1'b1, {hi, lo} <= 16'h0005)
      rd(3'h3, lo);
      `CHK("noflag", 1'b0, lo[0])
      wr(3'h1, 8'h34);
      wr(3'h2, 8'h12);
      wr(3'h6, 8'h01);
      capture_event <= 1'b1;
      idle(1);
      capture_event <= 1'b0;
      rd(3'h4, lo);
      rd(3'h5, hi);
      `CHK("capture", 16'h1234, {hi, lo})
      give_verdict;
   end
endmodule // gst_timer_bench
`default_nettype wire
